/* File: bench/meter_peak_status_regs_tb.sv */
`timescale 1ns/1ns
module meter_peak_status_regs_tb;
  import mps_pkg::*;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sampleStrobe, peakWindowEnd, lineCycleMode, lineCycleEnd;
  logic [2:0][23:0] curMag, volMag;
  logic [2:0] activeBit30, reactiveBit30, apparentBit30, activeSign, reactiveSign, q;
  logic [23:0] activeSum, reactiveSum;
  logic hpfBypass, firstFreqOutput, secondFreqOutput;
  int miscompares, numChecks, expStat, bi, bv, pi, pv, n, m;
  logic [31:0] v;
  logic [7:0] sgn, sgnOld;
  logic [15:0] rstIdx[8] = '{IDX_HPF, IDX_CURRENT_PEAK, IDX_VOLTAGE_PEAK, IDX_STAT, IDX_CFG, IDX_SIGN,
                             IDX_PWID, IDX_SUM1};
  logic [31:0] rstVal[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0E88, 32'h0, 32'h0010, 32'h0};

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  mps_apb_host u_mps_apb_host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

  mps_regs #(.ADDR_W(18), .PWID_W(10)) u_mps_regs (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sampleStrobe(sampleStrobe),
    .curMag(curMag), .volMag(volMag), .peakWindowEnd(peakWindowEnd),
    .activeBit30(activeBit30), .reactiveBit30(reactiveBit30), .apparentBit30(apparentBit30),
    .lineCycleMode(lineCycleMode), .lineCycleEnd(lineCycleEnd), .activeSign(activeSign),
    .reactiveSign(reactiveSign), .activeSum(activeSum), .reactiveSum(reactiveSum),
    .activeQuantum(q[0]), .reactiveQuantum(q[1]), .apparentQuantum(q[2]),
    .hpfBypass(hpfBypass), .firstFreqOutput(firstFreqOutput),
    .secondFreqOutput(secondFreqOutput));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      input logic [31:0] exp, input logic expErr);
    logic [31:0] d;
    logic e;
    bit ok;
    u_mps_apb_host.xfer(w, idx, wd, d, e, ok);
    if (!ok) begin
      miscompares++;
      $display("BAD pready expected 1 seen 0");
      end_of_test();
    end else begin
      if (!w) check($sformatf("read %h", idx), d, exp);
      check($sformatf("pslverr %h", idx), {31'h0, e}, {31'h0, expErr});
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0, exp, 1'b0);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd, 32'h0, 1'b0);
  endtask

  // clearing every flag keeps the model simple: each test starts from zero
  task automatic clr;
    wr(IDX_STAT, 32'h0000FFFF);
    expStat = 0;
    rd(IDX_STAT, 32'h0);
  endtask

  task automatic pulse(input logic [2:0] val, output int low1, output int low2);
    @(posedge clk_sys);
    q <= val;
    @(posedge clk_sys);
    q <= 3'h0;
    low1 = 0;
    low2 = 0;
    repeat (12) begin
      @(negedge clk_sys);
      if (firstFreqOutput === 1'b0) low1++;
      if (secondFreqOutput === 1'b0) low2++;
    end
  endtask

  initial begin
    rstn = 1'b0;
    {sampleStrobe, peakWindowEnd, lineCycleMode, lineCycleEnd} = 4'h0;
    curMag = '0;
    volMag = '0;
    {activeBit30, reactiveBit30, apparentBit30, activeSign, reactiveSign, q} = 18'h0;
    activeSum = 24'h0;
    reactiveSum = 24'h0;
    miscompares = 0;
    numChecks = 0;
    expStat = 0;
    sgnOld = 8'h00;
    void'($urandom(75));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rstIdx[i]) rd(rstIdx[i], rstVal[i]);
    xfer(1'b0, 16'h0001, 32'h0, 32'h0, 1'b1);
    wr(IDX_CURRENT_PEAK, 32'hFFFFFFFF);
    rd(IDX_CURRENT_PEAK, 32'h0);
    $display("test reset done");
    v = $urandom_range(1, 32'h00FFFFFF);
    wr(IDX_HPF, v);
    rd(IDX_HPF, v);
    check("hpfBypass", {31'h0, hpfBypass}, 32'h1);
    wr(IDX_HPF, 32'hFF000000);
    rd(IDX_HPF, 32'h0);
    check("hpfBypass", {31'h0, hpfBypass}, 32'h0);
    $display("test bypass done");
    for (int w = 0; w < 2; w++) begin
      bi = -1;
      bv = -1;
      repeat (4) begin
        @(posedge clk_sys);
        sampleStrobe <= 1'b1;
        for (int p = 0; p < 3; p++) begin
          n = $urandom_range(0, 32'h00FFFFFF) >> (w * 4);
          m = $urandom_range(0, 32'h00FFFFFF) >> (w * 4);
          curMag[p] <= n[23:0];
          volMag[p] <= m[23:0];
          if (n > bi) begin bi = n; pi = p; end
          if (m > bv) begin bv = m; pv = p; end
        end
      end
      @(posedge clk_sys);
      sampleStrobe <= 1'b0;
      peakWindowEnd <= 1'b1;
      @(posedge clk_sys);
      peakWindowEnd <= 1'b0;
      rd(IDX_CURRENT_PEAK, {5'h00, 3'h1 << pi, bi[23:0]});
      rd(IDX_VOLTAGE_PEAK, {5'h00, 3'h1 << pv, bv[23:0]});
    end
    $display("test peaks done");
    for (int g = 0; g < 3; g++) begin
      @(posedge clk_sys);
      n = $urandom_range(0, 2);
      if (g == 0) activeBit30 <= activeBit30 ^ (3'h1 << n);
      if (g == 1) reactiveBit30 <= reactiveBit30 ^ (3'h1 << n);
      if (g == 2) apparentBit30 <= apparentBit30 ^ (3'h1 << n);
      expStat = 1 << (2 * g);
      rd(IDX_STAT, expStat);
      rd(IDX_STAT, expStat);
      clr();
    end
    $display("test energy done");
    for (int md = 0; md < 2; md++) begin
      @(posedge clk_sys);
      lineCycleMode <= md[0];
      lineCycleEnd <= 1'b1;
      @(posedge clk_sys);
      lineCycleEnd <= 1'b0;
      rd(IDX_STAT, md << 5);
    end
    clr();
    $display("test line cycle done");
    wr(IDX_PWID, 32'hFFFFFFFF);
    rd(IDX_PWID, 32'h000003FF);
    wr(IDX_PWID, 32'h3);
    pulse(3'h1, n, m);
    check("first low", n, 0);
    rd(IDX_STAT, 32'h4000);
    clr();
    pulse(3'h2, n, m);
    check("second low", m, 0);
    rd(IDX_STAT, 32'h8000);
    clr();
    wr(IDX_CFG, 32'h0888);
    pulse(3'h1, n, m);
    check("first low", n, 3);
    rd(IDX_STAT, 32'h4000);
    clr();
    pulse(3'h2, n, m);
    check("second low", m, 3);
    rd(IDX_STAT, 32'h8000);
    clr();
    // both outputs on apparent power
    wr(IDX_CFG, 32'h0892);
    pulse(3'h1, n, m);
    check("first low", n, 0);
    check("second low", m, 0);
    pulse(3'h4, n, m);
    check("first low", n, 3);
    check("second low", m, 3);
    rd(IDX_STAT, 32'hC000);
    clr();
    wr(IDX_CFG, 32'h0888);
    $display("test freq outputs done");
    repeat (2) begin
      @(posedge clk_sys);
      v = $urandom();
      activeSign <= v[2:0];
      reactiveSign <= v[5:3];
      activeSum <= {v[6], v[30:8]};
      reactiveSum <= {v[7], 23'h0};
      sgn = {v[7], v[5:3], v[6], v[2:0]};
      rd(IDX_STAT, {sgn ^ sgnOld, 6'h00});
      rd(IDX_SIGN, sgn);
      rd(IDX_SUM1, {{9{v[6]}}, v[30:8]});
      sgnOld = sgn;
      clr();
    end
    $display("test signs done");
    end_of_test();
  end
endmodule // meter_peak_status_regs_tb

/* File: bench/mps_apb_host.sv */
`timescale 1ns/1ns
module mps_apb_host (
  // clock
  input  wire logic        clk_sys,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [17:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 18'h00000;
    pwdata  = 32'h00000000;
  end

  // request held until pready is sampled high or 20 access cycles pass; no latency is assumed
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output bit ok);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok  = (pready === 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // mps_apb_host

/* File: core/mps_freq_pulse.sv */
`timescale 1ns/1ns
module mps_freq_pulse
  import mps_pkg::*;
#(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // control
  input  wire logic         quantum,
  input  wire logic [W-1:0] widthCycles,
  input  wire logic         offOutput,
  // pin and event
  output logic              pinOut,
  output logic              fallPulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pin;
    logic         fall;
  } mps_pulse_t;

  mps_pulse_t pulse_reg;
  mps_pulse_t pulse_next;

  // a quantum that arrives while a pulse is still low is dropped
  always_comb begin
    pulse_next      = pulse_reg;
    pulse_next.fall = 1'b0;
    if (pulse_reg.cnt != '0) begin
      pulse_next.cnt = pulse_reg.cnt - W'(1);
    end else if (quantum) begin
      pulse_next.cnt  = (widthCycles == '0) ? W'(1) : widthCycles;
      pulse_next.fall = 1'b1; // event even when the pin is off
    end
    pulse_next.pin = offOutput | (pulse_next.cnt == '0);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_reg <= '{cnt: '0, pin: 1'b1, fall: 1'b0};
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  assign pinOut    = pulse_reg.pin;
  assign fallPulse = pulse_reg.fall;

endmodule // mps_freq_pulse

/* File: core/mps_pkg.sv */
package mps_pkg;

  // word indices; byte address is four times the index
  localparam logic [15:0] IDX_HPF   = 16'h43B6;
  localparam logic [15:0] IDX_CURRENT_PEAK = 16'hE500;
  localparam logic [15:0] IDX_VOLTAGE_PEAK = 16'hE501;
  localparam logic [15:0] IDX_STAT  = 16'hE502;
  localparam logic [15:0] IDX_CFG   = 16'hE610;
  localparam logic [15:0] IDX_SIGN  = 16'hE617;
  localparam logic [15:0] IDX_PWID  = 16'hE680;
  localparam logic [15:0] IDX_SUM1  = 16'hE681;

  // values after reset
  localparam logic [23:0] HPF_RST  = 24'h000000;
  localparam logic [15:0] CFG_RST  = 16'h0E88;
  localparam logic [9:0]  PWID_RST = 10'h010;

  // field positions
  localparam int PEAK_PHASE_LSB = 24;
  localparam int CFG_SEL1_LSB   = 0;
  localparam int CFG_SEL2_LSB   = 3;
  localparam int CFG_DIS1       = 9;
  localparam int CFG_DIS2       = 10;
  localparam int ST_LINE        = 5;
  localparam int ST_SIGN_LSB    = 6;
  localparam int ST_CF1         = 14;
  localparam int ST_CF2         = 15;
  localparam logic [15:0] ST_RSVD = 16'h000A;

  // power sources of a frequency output
  localparam logic [2:0] SRC_ACTIVE   = 3'h0;
  localparam logic [2:0] SRC_REACTIVE = 3'h1;
  localparam logic [2:0] SRC_APPARENT = 3'h2;

  // signed 24-bit value as a 32-bit word
  function automatic logic [31:0] sx24(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  // unsigned 10-bit value as a 16-bit word
  function automatic logic [15:0] zp10(input logic [9:0] v);
    return {6'h00, v};
  endfunction

endpackage

/* File: core/mps_regs.sv */
// Notes on behaviour
// - any non-zero bypass value disables all channel high-pass filters
// - current peak magnitude sits in bits 23..0
// - bits 24..26 of current peak mark phase A, B, C
// - bits 31..27 of both peak registers read zero
// - voltage peak magnitude sits in bits 23..0
// - bits 24..26 of voltage peak mark phase A, B, C
// - status bit 0 sets when bit 30 of any active energy changes
// - status bit 2 sets when bit 30 of any reactive energy changes
// - status bit 4 sets when bit 30 of any apparent energy changes
// - status bits 1 and 3 always read zero
// - status bit 5 sets at end of line-cycle integration in that mode
// - bits 6..8 flag active sign changes; new sign in sign bits 0..2
// - bits 10..12 flag reactive sign changes; new sign in sign bits 4..6
// - bits 9, 13 flag output sum sign change; sign in bits 3, 7
// - bits 14, 15 set on each low pulse of first or second output
// - first output pulse flag still sets while its pin is disabled
// - config bits 2..0 choose the first output power source
// - a 24-bit signed value reads sign-extended to 32 bits
// - a 10-bit unsigned value reads as 16 bits, top six zero
// - config bit 10 disables second output, bits 5..3 pick its source
`timescale 1ns/1ns
module mps_regs
  import mps_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int PWID_W = 10
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // peak detection samples
  input  wire logic               sampleStrobe,
  input  wire logic [2:0][23:0]   curMag,
  input  wire logic [2:0][23:0]   volMag,
  input  wire logic               peakWindowEnd,
  // energy accumulators, bit 30 per phase
  input  wire logic [2:0]         activeBit30,
  input  wire logic [2:0]         reactiveBit30,
  input  wire logic [2:0]         apparentBit30,
  // line-cycle accumulation
  input  wire logic               lineCycleMode,
  input  wire logic               lineCycleEnd,
  // phase power signs, one is negative
  input  wire logic [2:0]         activeSign,
  input  wire logic [2:0]         reactiveSign,
  // summed powers and energy quanta
  input  wire logic [23:0]        activeSum,
  input  wire logic [23:0]        reactiveSum,
  input  wire logic               activeQuantum,
  input  wire logic               reactiveQuantum,
  input  wire logic               apparentQuantum,
  // filter control and frequency outputs
  output logic                    hpfBypass,
  output logic                    firstFreqOutput,
  output logic                    secondFreqOutput
);

  typedef struct packed {
    logic [23:0]       hpf;
    logic              hpfOff;
    logic [15:0]       cfg;
    logic [PWID_W-1:0] pwid;
    logic [15:0]       status;
    logic [7:0]        sign;
    logic [26:0]       curPeak;
    logic [26:0]       volPeak;
    logic [26:0]       curRun;
    logic [26:0]       volRun;
    logic [8:0]        e30;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } mps_state_t;

  mps_state_t regs_reg;
  mps_state_t regs_next;

  // largest of three phase magnitudes, tagged with a one-hot phase
  function automatic logic [26:0] max3(input logic [2:0][23:0] m);
    logic [26:0] r;
    r = {3'b001, m[0]};
    if (m[1] > r[23:0]) begin
      r = {3'b010, m[1]};
    end
    if (m[2] > r[23:0]) begin
      r = {3'b100, m[2]};
    end
    return r;
  endfunction

  // running peak; equal values keep the older phase
  function automatic logic [26:0] keepPeak(input logic [26:0] run,
                                           input logic [26:0] cand);
    return (cand[23:0] > run[23:0]) ? cand : run;
  endfunction

  // summed power feeding an output; apparent power is never negative
  function automatic logic [23:0] srcSum(input logic [2:0]  sel,
                                         input logic [23:0] a,
                                         input logic [23:0] r);
    logic [23:0] v;
    v = 24'h000000;
    if (sel == SRC_ACTIVE) begin
      v = a;
    end else if (sel == SRC_REACTIVE) begin
      v = r;
    end
    return v;
  endfunction

  // energy quantum steering an output
  function automatic logic srcQuantum(input logic [2:0] sel,
                                      input logic       a,
                                      input logic       r,
                                      input logic       v);
    logic q;
    q = 1'b0;
    if (sel == SRC_ACTIVE) begin
      q = a;
    end else if (sel == SRC_REACTIVE) begin
      q = r;
    end else if (sel == SRC_APPARENT) begin
      q = v;
    end
    return q;
  endfunction

  logic [15:0] idx;
  logic        aligned;
  logic        setupCyc;
  logic        wrAcc;
  logic [2:0]  sel1;
  logic [2:0]  sel2;
  logic [23:0] sum1;
  logic [23:0] sum2;
  logic        q1;
  logic        q2;
  logic        cf1Fall;
  logic        cf2Fall;
  logic [15:0] evt;
  logic [15:0] clr;
  logic [7:0]  newSign;
  logic [26:0] curCand;
  logic [26:0] volCand;

  assign idx      = paddr[17:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign setupCyc = psel & ~penable;
  // a write lands only at the edge that completes the access
  assign wrAcc    = psel & penable & regs_reg.pready & pwrite;

  assign sel1 = regs_reg.cfg[CFG_SEL1_LSB +: 3];
  assign sel2 = regs_reg.cfg[CFG_SEL2_LSB +: 3];
  assign sum1 = srcSum(sel1, activeSum, reactiveSum);
  assign sum2 = srcSum(sel2, activeSum, reactiveSum);
  assign q1   = srcQuantum(sel1, activeQuantum, reactiveQuantum, apparentQuantum);
  assign q2   = srcQuantum(sel2, activeQuantum, reactiveQuantum, apparentQuantum);

  mps_freq_pulse #(
    .W (PWID_W)
  ) u_first (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .quantum     (q1),
    .widthCycles (regs_reg.pwid),
    .offOutput   (regs_reg.cfg[CFG_DIS1]),
    .pinOut      (firstFreqOutput),
    .fallPulse   (cf1Fall)
  );

  mps_freq_pulse #(
    .W (PWID_W)
  ) u_second (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .quantum     (q2),
    .widthCycles (regs_reg.pwid),
    .offOutput   (regs_reg.cfg[CFG_DIS2]),
    .pinOut      (secondFreqOutput),
    .fallPulse   (cf2Fall)
  );

  // sign register layout matches status bits 13..6 one to one
  assign newSign = {sum2[23], reactiveSign, sum1[23], activeSign};

  assign curCand = sampleStrobe ? keepPeak(regs_reg.curRun, max3(curMag))
                                : regs_reg.curRun;
  assign volCand = sampleStrobe ? keepPeak(regs_reg.volRun, max3(volMag))
                                : regs_reg.volRun;

  always_comb begin
    evt    = 16'h0000;
    evt[0] = |(regs_reg.e30[2:0] ^ activeBit30);
    evt[2] = |(regs_reg.e30[5:3] ^ reactiveBit30);
    evt[4] = |(regs_reg.e30[8:6] ^ apparentBit30);
    evt[ST_LINE] = lineCycleMode & lineCycleEnd;
    evt[ST_SIGN_LSB +: 8] = newSign ^ regs_reg.sign;
    evt[ST_CF1] = cf1Fall;
    evt[ST_CF2] = cf2Fall;
  end

  assign clr = (wrAcc && aligned && idx == IDX_STAT) ? pwdata[15:0] : 16'h0000;

  always_comb begin
    regs_next         = regs_reg;
    regs_next.e30     = {apparentBit30, reactiveBit30, activeBit30};
    regs_next.sign    = newSign;
    // an event in the clearing cycle survives
    regs_next.status  = ((regs_reg.status & ~clr) | evt) & ~ST_RSVD;

    // peak capture closes a window and starts the next one from zero
    if (peakWindowEnd) begin
      regs_next.curPeak = curCand;
      regs_next.volPeak = volCand;
      regs_next.curRun  = '0;
      regs_next.volRun  = '0;
    end else begin
      regs_next.curRun  = curCand;
      regs_next.volRun  = volCand;
    end

    if (wrAcc && aligned) begin
      unique case (idx)
        IDX_HPF:  regs_next.hpf  = pwdata[23:0];
        IDX_CFG:  regs_next.cfg  = pwdata[15:0];
        IDX_PWID: regs_next.pwid = pwdata[PWID_W-1:0];
        default:  regs_next.hpf  = regs_reg.hpf;
      endcase
    end
    regs_next.hpfOff = |regs_next.hpf;

    // answer one cycle after setup, so every access has one wait-free phase
    regs_next.pready  = setupCyc & ~regs_reg.pready;
    regs_next.pslverr = 1'b0;
    regs_next.prdata  = 32'h00000000;
    if (setupCyc) begin
      if (!aligned) begin
        regs_next.pslverr = 1'b1;
      end else if (!pwrite) begin
        unique case (idx)
          IDX_HPF:   regs_next.prdata = {8'h00, regs_reg.hpf};
          IDX_CURRENT_PEAK: regs_next.prdata = {5'h00, regs_reg.curPeak};
          IDX_VOLTAGE_PEAK: regs_next.prdata = {5'h00, regs_reg.volPeak};
          IDX_STAT:  regs_next.prdata = {16'h0000, regs_reg.status};
          IDX_CFG:   regs_next.prdata = {16'h0000, regs_reg.cfg};
          IDX_SIGN:  regs_next.prdata = {24'h000000, regs_reg.sign};
          IDX_PWID:  regs_next.prdata = {16'h0000, zp10(regs_reg.pwid)};
          IDX_SUM1:  regs_next.prdata = sx24(sum1);
          default:   regs_next.pslverr = 1'b1;
        endcase
      end else begin
        unique case (idx)
          IDX_HPF, IDX_CURRENT_PEAK, IDX_VOLTAGE_PEAK, IDX_STAT,
          IDX_CFG, IDX_SIGN, IDX_PWID, IDX_SUM1: regs_next.pslverr = 1'b0;
          default:                               regs_next.pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regs_reg         <= '0;
      regs_reg.hpf     <= HPF_RST;
      regs_reg.cfg     <= CFG_RST;
      regs_reg.pwid    <= PWID_RST;
    end else begin
      regs_reg <= regs_next;
    end
  end

  assign pready    = regs_reg.pready;
  assign prdata    = regs_reg.prdata;
  assign pslverr   = regs_reg.pslverr;
  assign hpfBypass = regs_reg.hpfOff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  bypass_on_write_a: assert property (
    (wrAcc && aligned && idx == IDX_HPF && pwdata[23:0] != 24'h000000) |=> hpfBypass)
    else $error("bypass not raised by non-zero write");

  bypass_off_write_a: assert property (
    (wrAcc && aligned && idx == IDX_HPF && pwdata[23:0] == 24'h000000) |=> !hpfBypass)
    else $error("bypass not cleared by zero write");

  peak_top_zero_a: assert property (
    (setupCyc && !pwrite && aligned && (idx == IDX_CURRENT_PEAK || idx == IDX_VOLTAGE_PEAK))
      |=> pready && prdata[31:27] == 5'h00)
    else $error("peak read shows non-zero top bits");

  peak_latch_a: assert property (
    peakWindowEnd |=> regs_reg.curPeak == $past(curCand) && regs_reg.curRun == '0)
    else $error("current peak not latched at window end");

  apb_answer_a: assert property (
    (setupCyc && !regs_reg.pready) |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle after setup");

  stat_reserved_a: assert property (
    regs_reg.status[1] == 1'b0 && regs_reg.status[3] == 1'b0)
    else $error("reserved status bit set");

  set_wins_a: assert property (
    (regs_reg.e30[2:0] != activeBit30) |=> regs_reg.status[0])
    else $error("active half-full event lost");

  sign_flip_a: assert property (
    (activeSign[0] != regs_reg.sign[0])
      |=> regs_reg.status[ST_SIGN_LSB] && regs_reg.sign[0] == $past(activeSign[0]))
    else $error("phase sign change not flagged");

  line_done_a: assert property (
    (lineCycleEnd && !lineCycleMode && !regs_reg.status[ST_LINE]) |=> !regs_reg.status[ST_LINE])
    else $error("line-cycle flag set outside its mode");

  flag_hold_a: assert property (
    (regs_reg.status[ST_CF1] && clr[ST_CF1] == 1'b0) |=> regs_reg.status[ST_CF1])
    else $error("output pulse flag dropped without a clear");

  // a quantum is only taken while no pulse is running
  cf_flag_a: assert property (
    (q1 && u_first.pulse_reg.cnt == '0 && regs_reg.cfg[CFG_DIS1])
      |=> ##1 regs_reg.status[ST_CF1])
    else $error("first output pulse not flagged while disabled");

  cf2_flag_a: assert property (
    (q2 && u_second.pulse_reg.cnt == '0) |=> ##1 regs_reg.status[ST_CF2])
    else $error("second output pulse not flagged");

  bad_addr_a: assert property (
    (setupCyc && !regs_reg.pready && !aligned) |=> pready && pslverr)
    else $error("misaligned access not refused");

endmodule // mps_regs
